// ### design/itp_defines.vh
`ifndef ITP_DEFINES_VH
`define ITP_DEFINES_VH

// Word offsets of the register map (byte address = offset).
`define ITP_OFF_COUNT    8'h00
`define ITP_OFF_SCALE    8'h04
`define ITP_OFF_PERIOD   8'h08
`define ITP_OFF_CTRL     8'h0C
`define ITP_OFF_STATUS   8'h10

// Control register fields.
`define ITP_CTRL_EN_BIT  0

// Status register fields.
`define ITP_STAT_EXP_BIT 0
`define ITP_STAT_RUN_BIT 1

// Reset values.
`define ITP_RST_COUNT    16'h0000
`define ITP_RST_SCALE    8'h00
`define ITP_RST_PERIOD   16'h0000
`define ITP_RST_CTRL     1'b0
`define ITP_RST_EXPIRED  1'b0

// Register address width in bits.
`define ITP_ADR_W        8

// Width of one bus byte lane in bits.
`define ITP_LANE_W       8

`endif

// ### design/itp_prescale.v
`timescale 1ns/1ps
`include "itp_defines.vh"

// Counts processor cycles; one strobe every scale+1 cycles while enabled.
module itp_prescale #(
	parameter SCALE_W = 8
)(
	input  wire               clk_i,
	input  wire               rst_i,
	input  wire               en_i,
	input  wire [SCALE_W-1:0] scale_i,
	output reg                tick_o
);

	reg [SCALE_W-1:0] cnt_q;

	always @(posedge clk_i)
	begin
		if (rst_i || !en_i)
		begin
			cnt_q  <= {SCALE_W{1'b0}};
			tick_o <= 1'b0;
		end
		else if (cnt_q == {SCALE_W{1'b0}})
		begin
			cnt_q  <= scale_i;
			tick_o <= 1'b1;
		end
		else
		begin
			cnt_q  <= cnt_q - {{(SCALE_W-1){1'b0}}, 1'b1};
			tick_o <= 1'b0;
		end
	end

endmodule // itp_prescale

// ### design/itp_downcount.v
`timescale 1ns/1ps
`include "itp_defines.vh"

// Down-counter with reload; a software write takes priority over a tick.
module itp_downcount #(
	parameter CNT_W = 16
)(
	input  wire             clk_i,
	input  wire             rst_i,
	input  wire             tick_i,
	input  wire             wr_i,
	input  wire [CNT_W-1:0] wdata_i,
	input  wire [CNT_W-1:0] period_i,
	output reg  [CNT_W-1:0] count_o,
	output reg              zero_o
);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			count_o <= `ITP_RST_COUNT;
			zero_o  <= 1'b0;
		end
		else if (wr_i)
		begin
			count_o <= wdata_i;
			zero_o  <= 1'b0;
		end
		else if (tick_i && count_o == {CNT_W{1'b0}})
		begin
			count_o <= period_i;
			zero_o  <= 1'b1;
		end
		else if (tick_i)
		begin
			count_o <= count_o - {{(CNT_W-1){1'b0}}, 1'b1};
			zero_o  <= 1'b0;
		end
		else
			zero_o  <= 1'b0;
	end

endmodule // itp_downcount

// ### design/itp_timer.v
// Local design decisions: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`include "itp_defines.vh"

module itp_timer #(
	parameter CNT_W   = 16,
	parameter SCALE_W = 8
)(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [7:0]  adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	output reg         err_o,
	output reg         timer_irq_o
);

	// Codes that pick the register placed on the read data.
	localparam RSEL_NONE   = 3'b000;
	localparam RSEL_COUNT  = 3'b001;
	localparam RSEL_SCALE  = 3'b010;
	localparam RSEL_PERIOD = 3'b011;
	localparam RSEL_CTRL   = 3'b100;
	localparam RSEL_STATUS = 3'b101;

	// Byte lanes that carry the period register; lanes above them are ignored.
	localparam PER_LANES   = CNT_W / `ITP_LANE_W;

	// Software-visible state and its next values.
	reg  [SCALE_W-1:0] scale_q;
	reg  [SCALE_W-1:0] scale_d;
	reg  [CNT_W-1:0]   period_q;
	wire [CNT_W-1:0]   period_d;
	reg                en_q;
	reg                en_d;
	reg                expired_q;
	reg                expired_d;

	// Next values of the registered outputs.
	reg  [31:0]        dat_d;
	reg                ack_d;
	reg                err_d;
	reg                irq_d;
	reg  [2:0]         rsel;

	// Strobes between the bus side and the counting side.
	wire               tick;
	wire               zero;
	wire [CNT_W-1:0]   count;

	// Bus decode.
	wire               req;
	wire               wr;
	wire               rd;
	wire               hit_count;
	wire               hit_scale;
	wire               hit_period;
	wire               hit_ctrl;
	wire               hit_status;
	wire               hit;
	wire               wr_count;
	wire               wr_scale;
	wire               wr_period;
	wire               wr_ctrl;
	wire               clr_expired;
	genvar             lane;

	// A request is taken only while no answer stands, so a held strobe is served again every second cycle.
	assign req         = cyc_i && stb_i && !ack_o && !err_o;
	assign wr          = req && we_i;
	assign rd          = req && !we_i;

	assign hit_count   = (adr_i == `ITP_OFF_COUNT);
	assign hit_scale   = (adr_i == `ITP_OFF_SCALE);
	assign hit_period  = (adr_i == `ITP_OFF_PERIOD);
	assign hit_ctrl    = (adr_i == `ITP_OFF_CTRL);
	assign hit_status  = (adr_i == `ITP_OFF_STATUS);
	assign hit         = hit_count || hit_scale || hit_period || hit_ctrl || hit_status;

	// The count is loaded whole, so the counter never runs on half of a new value.
	assign wr_count    = wr && hit_count && sel_i[0] && sel_i[1];
	assign wr_scale    = wr && hit_scale && sel_i[0];
	assign wr_period   = wr && hit_period;
	assign wr_ctrl     = wr && hit_ctrl && sel_i[0];
	assign clr_expired = wr && hit_status && sel_i[0] && dat_i[`ITP_STAT_EXP_BIT];

	// Each lane of the period register takes its byte only when its select is set.
	generate
		for (lane = 0; lane < PER_LANES; lane = lane + 1)
		begin : g_period_lane
			assign period_d[lane*`ITP_LANE_W +: `ITP_LANE_W] = (wr_period && sel_i[lane]) ?
				dat_i[lane*`ITP_LANE_W +: `ITP_LANE_W] : period_q[lane*`ITP_LANE_W +: `ITP_LANE_W];
		end
	endgenerate

	itp_prescale #(
		.SCALE_W (SCALE_W)
	) u_pre (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.en_i    (en_q),
		.scale_i (scale_q),
		.tick_o  (tick)
	);

	itp_downcount #(
		.CNT_W    (CNT_W)
	) u_cnt (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.tick_i   (tick),
		.wr_i     (wr_count),
		.wdata_i  (dat_i[CNT_W-1:0]),
		.period_i (period_q),
		.count_o  (count),
		.zero_o   (zero)
	);

	// A new scale takes effect at the next prescaler reload, not in mid-step.
	always @*
	begin
		scale_d = scale_q;
		if (wr_scale)
			scale_d = dat_i[SCALE_W-1:0];
	end

	// Clearing the enable also clears the prescaler, so a restart ticks one cycle after the enable is set, not a full step later.
	always @*
	begin
		en_d = en_q;
		if (wr_ctrl)
			en_d = dat_i[`ITP_CTRL_EN_BIT];
	end

	// Sticky expiry flag, write one to clear; a new expiry wins over the clear so none is lost.
	always @*
	begin
		expired_d = expired_q;
		if (clr_expired)
			expired_d = 1'b0;
		if (zero)
			expired_d = 1'b1;
	end

	// Only one offset can match, so the priority order here is immaterial.
	always @*
	begin
		rsel = RSEL_NONE;
		if (hit_count)
			rsel = RSEL_COUNT;
		else if (hit_scale)
			rsel = RSEL_SCALE;
		else if (hit_period)
			rsel = RSEL_PERIOD;
		else if (hit_ctrl)
			rsel = RSEL_CTRL;
		else if (hit_status)
			rsel = RSEL_STATUS;
	end

	// Read data is zero outside a read answer, so a stale value never shows on the bus.
	always @*
	begin
		dat_d = {32{1'b0}};
		if (rd)
		begin
			case (rsel)
				RSEL_COUNT:
					dat_d[CNT_W-1:0] = count;
				RSEL_SCALE:
					dat_d[SCALE_W-1:0] = scale_q;
				RSEL_PERIOD:
					dat_d[CNT_W-1:0] = period_q;
				RSEL_CTRL:
					dat_d[`ITP_CTRL_EN_BIT] = en_q;
				RSEL_STATUS:
				begin
					dat_d[`ITP_STAT_EXP_BIT] = expired_q;
					dat_d[`ITP_STAT_RUN_BIT] = en_q;
				end
				default:
					dat_d = {32{1'b0}};
			endcase
		end
	end

	// Single-cycle answer: ack or err one cycle after the request is taken.
	always @*
	begin
		ack_d = req && hit;
		err_d = req && !hit;
	end

	// The request toward the processor interrupt logic is one pulse per expiry.
	always @*
	begin
		irq_d = zero;
	end

	// State registers, all cleared by the synchronous reset.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			scale_q <= `ITP_RST_SCALE;
		end
		else
		begin
			scale_q <= scale_d;
		end
	end

	// The period is read only at a reload, so a write between expiries shapes the next interval.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			period_q <= `ITP_RST_PERIOD;
		end
		else
		begin
			period_q <= period_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			en_q <= `ITP_RST_CTRL;
		end
		else
		begin
			en_q <= en_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			expired_q <= `ITP_RST_EXPIRED;
		end
		else
		begin
			expired_q <= expired_d;
		end
	end

	// Every output leaves a flip-flop, so the bus sees no combinational path from its own inputs.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dat_o <= {32{1'b0}};
		end
		else
		begin
			dat_o <= dat_d;
		end
	end

	// The answer drops by itself in the next cycle, even while the strobe is still held.
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			err_o <= 1'b0;
		end
		else
		begin
			ack_o <= ack_d;
			err_o <= err_d;
		end
	end

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			timer_irq_o <= 1'b0;
		end
		else
		begin
			timer_irq_o <= irq_d;
		end
	end

endmodule // itp_timer

// ### dv/itp_checker.sv
`timescale 1ns/1ps
module itp_checker (
	input wire        clk_i,
	input wire        rst_i,
	input wire        cyc_i,
	input wire        stb_i,
	input wire [7:0]  adr_i,
	input wire [31:0] dat_o,
	input wire        ack_o,
	input wire        err_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	wire rq = cyc_i && stb_i && !ack_o && !err_o;
	property p_ack1; ack_o |=> !ack_o; endproperty
	a_ack1: assert property (p_ack1) else $error("ack held");
	property p_err1; err_o |=> !err_o; endproperty
	a_err1: assert property (p_err1) else $error("err held");
	property p_ans; rq |=> (ack_o || err_o); endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	property p_map; rq && adr_i < 8'h14 && adr_i[1:0] == 2'h0 |=> ack_o; endproperty
	a_map: assert property (p_map) else $error("mapped not acked");
	property p_unm; rq && adr_i >= 8'h14 |=> err_o && !ack_o; endproperty
	a_unm: assert property (p_unm) else $error("unmapped acked");
	property p_excl; !(ack_o && err_o); endproperty
	a_excl: assert property (p_excl) else $error("ack with err");
	property p_dat; !ack_o |-> dat_o == 32'h0; endproperty
	a_dat: assert property (p_dat) else $error("data without ack");
endmodule // itp_checker
bind itp_timer itp_checker u_chk (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o));

// ### dv/itp_timer_tb.sv
`timescale 1ns/1ps
module itp_timer_tb;
	logic        clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
	logic [7:0]  adr_i = 0;
	logic [3:0]  sel_i = 0;
	logic [31:0] dat_i = 0, dat_o, rd;
	logic        ack_o, err_o, timer_irq_o;
	int          mismatches = 0, n_compared = 0, cyc_n = 0;
	always #4 clk_i = ~clk_i;
	itp_timer uut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
		.sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .err_o(err_o), .timer_irq_o(timer_irq_o));
	task end_sim;
		begin
			$display("compared %0d mismatches %0d", n_compared, mismatches);
			if (mismatches == 0 && n_compared > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask
	// A hung handshake would otherwise stall the run forever.
	always @(posedge clk_i)
	begin
		cyc_n <= cyc_n + 1;
		if (cyc_n == 5000)
		begin
			mismatches++;
			end_sim;
		end
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		begin
			n_compared++;
			if (s !== e)
			begin
				mismatches++;
				$display("Error %s exp %h got %h", n, e, s);
			end
		end
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
		begin
			@(posedge clk_i);
			cyc_i <= 1;
			stb_i <= 1;
			we_i <= w;
			adr_i <= a;
			sel_i <= 4'hF;
			dat_i <= d;
			do @(posedge clk_i); while (!(ack_o || err_o));
			rd = dat_o;
			chk("err", {31'h0, e}, {31'h0, err_o});
			cyc_i <= 0;
			stb_i <= 0;
		end
	endtask
	task t_regs;
		begin
			wb(0, 8'h04, 0, 0);
			chk("scale", 0, rd);
			wb(0, 8'h08, 0, 0);
			chk("period", 0, rd);
			wb(1, 8'h00, 32'h0000_1234, 0);
			wb(0, 8'h00, 0, 0);
			chk("count", 32'h0000_1234, rd);
			wb(0, 8'h20, 0, 1);
		end
	endtask
	task t_int(input logic [7:0] s, input logic [15:0] p);
		int k;
		begin
			wb(1, 8'h0C, 0, 0);
			wb(1, 8'h04, {24'h0, s}, 0);
			wb(1, 8'h08, {16'h0, p}, 0);
			wb(1, 8'h00, 0, 0);
			wb(1, 8'h0C, 32'h1, 0);
			while (!timer_irq_o) @(posedge clk_i);
			@(posedge clk_i);
			k = 1;
			while (!timer_irq_o)
			begin
				@(posedge clk_i);
				k++;
			end
			chk("interval", (p + 1) * (s + 1), k);
			wb(0, 8'h10, 0, 0);
			chk("status", 32'h0000_0003, rd);
			wb(1, 8'h0C, 0, 0);
			wb(1, 8'h10, 32'h1, 0);
			wb(0, 8'h10, 0, 0);
			chk("status clear", 32'h0000_0000, rd);
		end
	endtask
	initial
	begin
		repeat (16) @(posedge clk_i);
		rst_i <= 0;
		t_regs;
		t_int(8'h02, 16'h0003);
		t_int(8'h00, 16'h0005);
		end_sim;
	end
endmodule // itp_timer_tb
